/* verilog/xss_top.sv */
// ===========================================================================
// xss_top: task switched trap and extended state save/restore control
// ===========================================================================
// assumes a classic Wishbone master in the SYS_CLK domain; the memory image
// (header bitmap, must-zero word, two component areas) is held here as
// registers standing in for the save region.
//
// Rules of the document (RULE5 and RULE6 are os software duties)
// (RULE1) task switched set: fp/vector op faults first
// (RULE2) checksum and bit count never fault
// (RULE3) flag set by write or hardware switch
// (RULE4) clear op clears flag after handler save
// (RULE5) os sets flag by ownership on switch
// (RULE6) handler: save, restore, set owner, clear
// (RULE7) image: 512 legacy, 64 header, components
// (RULE8) ident bit 26 support, 27 os enable
// (RULE9) extension control bit 18 enables feature
// (RULE10) mask readable anywhere, written ring 0 only
// (RULE11) save and restore act on selected components
// (RULE12) save sets saved component bitmap bit
// (RULE13) software editing image sets bitmap bit
// (RULE14) bitmap order equals mask order, two bits
// (RULE15) header and region 64-byte aligned
// (RULE16) bitmap at offset zero, reserved must-zero
// (RULE17) restore: bitmap one loads, zero inits
// (RULE18) zero bitmap bit initialises regardless of image
// (RULE19) unselected component neither loaded nor initialised
// (RULE20) save/restore of fp state faults when flag set
// (RULE21) clearing mask bit 0 gives protection fault
// (RULE22) selected but disabled component stays untouched
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps

module xss_top
(
    input  wire logic                 SYS_CLK,
    input  wire logic                 RESETN,
    input  wire xss_pkg::xss_wb_req_t WB_REQ,
    output xss_pkg::xss_wb_rsp_t      WB_RSP,
    output logic                      FAULT_NM,
    output logic                      FAULT_GP
);

    // =======================================================================
    // state
    // =======================================================================
    typedef struct packed {
        logic                ack;
        logic [31:0]         rdat;
        logic                ts;
        logic                osxe;
        logic [1:0]          fmask;
        logic [31:0]         opnd_lo;
        logic [31:0]         opnd_hi;
        logic [31:0]         area;
        logic [1:0]          bitmap;
        logic [31:0]         hdr_rsv;
        logic [1:0][31:0]    img;
        logic [1:0][31:0]    st;
        logic [1:0]          res;
        logic [2:0]          sts;
        logic                nm;
        logic                gp;
    } xss_state_t;

    xss_state_t q;
    xss_state_t d;
    logic             wr_take;
    logic             cmd_wr;
    xss_pkg::xss_op_t cmd_op;
    logic [1:0]       cmd_ring;
    logic [1:0]       sel_en;
    logic             fp_sel;
    logic             region_ok;
    logic [31:0]      hdr_adr;

    // =======================================================================
    // helpers
    // =======================================================================
    // byte-lane merge so partial writes leave other lanes alone
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction

    // read mux; unmapped offsets and the command word read as zero
    function automatic logic [31:0] rd_word(input xss_state_t s,
                                            input logic [7:0] adr);
        logic [31:0] r;
        r = xss_pkg::WORD_ZERO;
        case (adr)
            xss_pkg::ADR_PCR:    r[xss_pkg::TS_BIT] = s.ts;
            xss_pkg::ADR_ECR:    r[xss_pkg::OSXE_BIT] = s.osxe;
            xss_pkg::ADR_IDENT:
            begin
                r[xss_pkg::ID_SUP_BIT]  = 1'b1;   // [RULE8]
                r[xss_pkg::ID_OSXE_BIT] = s.osxe; // [RULE8] [RULE9]
            end
            xss_pkg::ADR_FM_LO:  r[1:0] = s.fmask;
            xss_pkg::ADR_OP_LO:  r = s.opnd_lo;
            xss_pkg::ADR_OP_HI:  r = s.opnd_hi;
            xss_pkg::ADR_STATUS: r[2:0] = s.sts;
            xss_pkg::ADR_AREA:   r = s.area;
            xss_pkg::ADR_HDR_BV: r[1:0] = s.bitmap;
            xss_pkg::ADR_HDR_RS: r = s.hdr_rsv;
            xss_pkg::ADR_IMG0:   r = s.img[0];
            xss_pkg::ADR_IMG1:   r = s.img[1];
            xss_pkg::ADR_ST0:    r = s.st[0];
            xss_pkg::ADR_ST1:    r = s.st[1];
            xss_pkg::ADR_RESULT: r[1:0] = s.res;
            default:             r = xss_pkg::WORD_ZERO;
        endcase
        return r;
    endfunction

    // =======================================================================
    // request decode
    // =======================================================================
    // a write lands on the edge where the master sees ack
    assign wr_take   = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & q.ack;
    assign cmd_wr    = wr_take & (WB_REQ.adr == xss_pkg::ADR_CMD)
                       & WB_REQ.sel[0];
    assign cmd_op    = xss_pkg::xss_op_t'(WB_REQ.dat[3:0]);
    assign cmd_ring  = WB_REQ.dat[5:4];
    // only components both selected and enabled are touched
    assign sel_en    = q.opnd_lo[1:0] & q.fmask;        // [RULE11] [RULE22]
    assign fp_sel    = |q.opnd_lo[1:0];                 // [RULE20]
    // header sits right after the legacy area, on a header-size boundary
    assign hdr_adr   = q.area + 32'(xss_pkg::LEGACY_SZ);            // [RULE7]
    assign region_ok = (hdr_adr[xss_pkg::ALIGN_BITS-1:0] == 6'h00); // [RULE15]

    // =======================================================================
    // next state
    // =======================================================================
    always_comb
    begin
        logic [2:0] set_s;
        logic [2:0] clr_s;
        logic       nm_e;
        logic       gp_e;
        d     = q;
        set_s = 3'h0;
        clr_s = 3'h0;
        nm_e  = 1'b0;
        gp_e  = 1'b0;
        d.ack = 1'b0;
        // registered ack: one wait cycle, dropped right after the handshake
        if (WB_REQ.cyc && WB_REQ.stb && !q.ack)
        begin
            d.ack  = 1'b1;
            d.rdat = rd_word(q, WB_REQ.adr);
        end
        if (wr_take)
        begin
            case (WB_REQ.adr)
                xss_pkg::ADR_PCR:
                    if (WB_REQ.sel[0])
                        d.ts = WB_REQ.dat[xss_pkg::TS_BIT];     // [RULE3]
                xss_pkg::ADR_ECR:
                    if (WB_REQ.sel[2])
                        d.osxe = WB_REQ.dat[xss_pkg::OSXE_BIT]; // [RULE9]
                xss_pkg::ADR_OP_LO:
                    d.opnd_lo = merge(q.opnd_lo, WB_REQ.dat, WB_REQ.sel);
                xss_pkg::ADR_OP_HI:
                    d.opnd_hi = merge(q.opnd_hi, WB_REQ.dat, WB_REQ.sel);
                xss_pkg::ADR_STATUS:
                    if (WB_REQ.sel[0])
                        clr_s = WB_REQ.dat[2:0];
                xss_pkg::ADR_AREA:
                    d.area = merge(q.area, WB_REQ.dat, WB_REQ.sel);
                // direct edits of the image by software
                xss_pkg::ADR_HDR_BV:
                    if (WB_REQ.sel[0])
                        d.bitmap = WB_REQ.dat[1:0];             // [RULE13]
                xss_pkg::ADR_HDR_RS:
                    d.hdr_rsv = merge(q.hdr_rsv, WB_REQ.dat, WB_REQ.sel);
                xss_pkg::ADR_IMG0:
                    d.img[0] = merge(q.img[0], WB_REQ.dat, WB_REQ.sel);
                xss_pkg::ADR_IMG1:
                    d.img[1] = merge(q.img[1], WB_REQ.dat, WB_REQ.sel);
                xss_pkg::ADR_ST0:
                    d.st[0] = merge(q.st[0], WB_REQ.dat, WB_REQ.sel);
                xss_pkg::ADR_ST1:
                    d.st[1] = merge(q.st[1], WB_REQ.dat, WB_REQ.sel);
                default: ;
            endcase
        end
        // command execution, resolved in the same edge as the write
        if (cmd_wr)
        begin
            set_s[xss_pkg::ST_DONE] = 1'b1;
            case (cmd_op)
                xss_pkg::OP_FPVEC:
                    nm_e = q.ts;                                // [RULE1]
                // general purpose only: the flag is never consulted
                xss_pkg::OP_CHKSUM, xss_pkg::OP_BITCNT:
                    nm_e = 1'b0;                                // [RULE2]
                xss_pkg::OP_HWTSW:
                    d.ts = 1'b1;                                // [RULE3]
                xss_pkg::OP_CLEAR_TASK_SWITCHED_OP:
                    if (cmd_ring != 2'h0)
                        gp_e = 1'b1;
                    else
                        d.ts = 1'b0;                            // [RULE4]
                xss_pkg::OP_RDMASK:
                    if (!q.osxe)
                        gp_e = 1'b1;
                    else
                        d.res = q.fmask;                        // [RULE10]
                // mask bit 0 must stay one; undefined bits stay zero
                xss_pkg::OP_WRMASK:
                    if (!q.osxe || cmd_ring != 2'h0 || !q.opnd_lo[0]
                        || q.opnd_lo[31:2] != 30'h0
                        || q.opnd_hi != xss_pkg::WORD_ZERO)
                        gp_e = 1'b1;                       // [RULE10] [RULE21]
                    else
                        d.fmask = q.opnd_lo[1:0];               // [RULE14]
                xss_pkg::OP_SAVE:
                    if (!q.osxe || !region_ok)
                        gp_e = 1'b1;                            // [RULE15]
                    else if (q.ts && fp_sel)
                        nm_e = 1'b1;                            // [RULE20]
                    else
                    begin
                        for (int i = 0; i < xss_pkg::NCOMP; i++)
                        begin
                            if (sel_en[i])
                            begin
                                d.img[i]    = q.st[i];          // [RULE11]
                                d.bitmap[i] = 1'b1;             // [RULE12]
                            end
                        end
                    end
                // a dirty must-zero header word refuses the restore
                xss_pkg::OP_RESTORE:
                    if (!q.osxe || !region_ok
                        || q.hdr_rsv != xss_pkg::WORD_ZERO)
                        gp_e = 1'b1;                       // [RULE15] [RULE16]
                    else if (q.ts && fp_sel)
                        nm_e = 1'b1;                            // [RULE20]
                    else
                    begin
                        for (int i = 0; i < xss_pkg::NCOMP; i++)
                        begin
                            // unselected or disabled: left as it is
                            if (sel_en[i])                 // [RULE19] [RULE22]
                                d.st[i] = q.bitmap[i] ? q.img[i]
                                    : xss_pkg::COMP_INIT; // [RULE17] [RULE18]
                        end
                    end
                default: ;
            endcase
        end
        set_s[xss_pkg::ST_NM] = nm_e;
        set_s[xss_pkg::ST_GP] = gp_e;
        // write one to clear; a same-cycle event wins over the clear
        d.sts = (q.sts & ~clr_s) | set_s;
        d.nm  = nm_e;
        d.gp  = gp_e;
    end

    // state register; reset values are constants only
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            q         <= '0;
            q.fmask   <= xss_pkg::FMASK_RST;
        end
        else
            q <= d;
    end

    // =======================================================================
    // outputs, all straight from flip-flops
    // =======================================================================
    assign WB_RSP.ack = q.ack;
    assign WB_RSP.dat = q.rdat;
    assign FAULT_NM   = q.nm;
    assign FAULT_GP   = q.gp;

    // =======================================================================
    // checks
    // =======================================================================
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    sequence s_nm_pulse;
        FAULT_NM ##1 !FAULT_NM;
    endsequence
    sequence s_gp_pulse;
        FAULT_GP ##1 !FAULT_GP;
    endsequence
    sequence s_ok_xfer;
        cmd_wr && q.osxe && region_ok && !(q.ts && fp_sel);
    endsequence
    property p_nm_fp;
        cmd_wr && cmd_op == xss_pkg::OP_FPVEC && q.ts |=> s_nm_pulse;
    endproperty
    a_nm_fp: assert property (p_nm_fp) // [RULE1]
        else $error("fp op with flag set did not fault");
    property p_gpr_nofault;
        cmd_wr && (cmd_op == xss_pkg::OP_CHKSUM
                   || cmd_op == xss_pkg::OP_BITCNT) |=> !FAULT_NM;
    endproperty
    a_gpr_nofault: assert property (p_gpr_nofault) // [RULE2]
        else $error("general purpose op raised device fault");
    property p_hw_ts;
        cmd_wr && cmd_op == xss_pkg::OP_HWTSW |=> q.ts;
    endproperty
    a_hw_ts: assert property (p_hw_ts) // [RULE3]
        else $error("hardware switch did not set flag");
    property p_clear_task_switched_op;
        cmd_wr && cmd_op == xss_pkg::OP_CLEAR_TASK_SWITCHED_OP && cmd_ring == 2'h0
            |=> !q.ts && !FAULT_GP;
    endproperty
    a_clear_task_switched_op: assert property (p_clear_task_switched_op) // [RULE4]
        else $error("clear op left flag set");
    property p_ident;
        WB_REQ.cyc && WB_REQ.stb && !q.ack
            && WB_REQ.adr == xss_pkg::ADR_IDENT
        |=> WB_RSP.ack && WB_RSP.dat[26] && WB_RSP.dat[27] == $past(q.osxe);
    endproperty
    a_ident: assert property (p_ident) // [RULE8]
        else $error("identification bits wrong");
    property p_wrmask_ring;
        cmd_wr && cmd_op == xss_pkg::OP_WRMASK && cmd_ring != 2'h0
            |=> s_gp_pulse and (q.fmask == $past(q.fmask) [*2]);
    endproperty
    a_wrmask_ring: assert property (p_wrmask_ring) // [RULE10]
        else $error("mask written outside ring 0");
    property p_bit0;
        cmd_wr && cmd_op == xss_pkg::OP_WRMASK && !q.opnd_lo[0]
            |=> FAULT_GP && q.fmask[0];
    endproperty
    a_bit0: assert property (p_bit0) // [RULE21]
        else $error("mask bit 0 cleared without fault");
    property p_save_bm;
        s_ok_xfer and (cmd_op == xss_pkg::OP_SAVE && sel_en[0])
            |=> q.bitmap[0] && q.img[0] == $past(q.st[0]);
    endproperty
    a_save_bm: assert property (p_save_bm) // [RULE12]
        else $error("save did not store component and bitmap");
    property p_rst_init;
        s_ok_xfer and (cmd_op == xss_pkg::OP_RESTORE && sel_en[1]
                       && q.hdr_rsv == xss_pkg::WORD_ZERO && !q.bitmap[1])
            |=> q.st[1] == xss_pkg::COMP_INIT;
    endproperty
    a_rst_init: assert property (p_rst_init) // [RULE18]
        else $error("restore did not initialise component");
    property p_rst_skip;
        cmd_wr && cmd_op == xss_pkg::OP_RESTORE && !sel_en[0]
            |=> $stable(q.st[0]);
    endproperty
    a_rst_skip: assert property (p_rst_skip) // [RULE19]
        else $error("unselected component was changed");
    property p_align;
        cmd_wr && cmd_op == xss_pkg::OP_SAVE && !region_ok
            |=> s_gp_pulse;
    endproperty
    a_align: assert property (p_align) // [RULE15]
        else $error("misaligned region not refused");
endmodule

/* shared/xss_pkg.sv */
// ===========================================================================
// xss_pkg: constants and carrier types of the extended state save block
// ===========================================================================
// assumes a 32-bit classic Wishbone slave port with byte addresses
package xss_pkg;

    // =======================================================================
    // register byte offsets
    // =======================================================================
    localparam logic [7:0] ADR_PCR    = 8'h00; // primary control register
    localparam logic [7:0] ADR_ECR    = 8'h04; // extension control register
    localparam logic [7:0] ADR_IDENT  = 8'h08; // identification feature word
    localparam logic [7:0] ADR_FM_LO  = 8'h0c; // feature enable mask, low
    localparam logic [7:0] ADR_FM_HI  = 8'h10; // feature enable mask, high
    localparam logic [7:0] ADR_OP_LO  = 8'h14; // component mask operand, low
    localparam logic [7:0] ADR_OP_HI  = 8'h18; // component mask operand, high
    localparam logic [7:0] ADR_CMD    = 8'h1c; // command issue
    localparam logic [7:0] ADR_STATUS = 8'h20; // sticky outcome flags
    localparam logic [7:0] ADR_AREA   = 8'h24; // save region base address
    localparam logic [7:0] ADR_HDR_BV = 8'h28; // image header bitmap
    localparam logic [7:0] ADR_HDR_RS = 8'h2c; // image header must-zero word
    localparam logic [7:0] ADR_IMG0   = 8'h30; // image area, component 0
    localparam logic [7:0] ADR_IMG1   = 8'h34; // image area, component 1
    localparam logic [7:0] ADR_ST0    = 8'h38; // live state, component 0
    localparam logic [7:0] ADR_ST1    = 8'h3c; // live state, component 1
    localparam logic [7:0] ADR_RESULT = 8'h40; // read mask result

    // =======================================================================
    // field positions, sizes and reset values
    // =======================================================================
    localparam int          TS_BIT      = 3;     // task switched flag
    localparam int          OSXE_BIT    = 18;    // os extended state enable
    localparam int          ID_SUP_BIT  = 26;    // save architecture support
    localparam int          ID_OSXE_BIT = 27;    // os enable mirror
    localparam int          NCOMP       = 2;     // defined components
    localparam int          LEGACY_SZ   = 512;   // legacy area bytes
    localparam int          HDR_SZ      = 64;    // header bytes and alignment
    localparam int          ALIGN_BITS  = 6;     // log2 of HDR_SZ
    localparam int          ST_NM       = 0;     // status: device unavailable
    localparam int          ST_GP       = 1;     // status: general protection
    localparam int          ST_DONE     = 2;     // status: op completed
    localparam logic [1:0]  FMASK_RST   = 2'h1;  // bit 0 always enabled
    localparam logic [31:0] COMP_INIT   = 32'h0; // hardware initial value
    localparam logic [31:0] WORD_ZERO   = 32'h0;

    // =======================================================================
    // command codes, written into the low nibble of the command register
    // =======================================================================
    typedef enum logic [3:0] {
        OP_NONE    = 4'h0,
        OP_FPVEC   = 4'h1, // floating point or vector instruction
        OP_CHKSUM  = 4'h2, // checksum_instruction
        OP_BITCNT  = 4'h3, // bit_count_instruction
        OP_HWTSW   = 4'h4, // native hardware task switch
        OP_CLEAR_TASK_SWITCHED_OP    = 4'h5, // clear_task_switched_op
        OP_RDMASK  = 4'h6, // read_mask_op
        OP_WRMASK  = 4'h7, // write_mask_op
        OP_SAVE    = 4'h8, // extended_state_save_op
        OP_RESTORE = 4'h9  // extended_state_restore_op
    } xss_op_t;

    // =======================================================================
    // bus carriers
    // =======================================================================
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } xss_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } xss_wb_rsp_t;

endpackage

/* tb/xss_os_model.sv */
// xss_os_model: software side that issues classic register bus cycles
// assumes one clock and a slave that answers with a one-cycle ack
`timescale 1ns/1ps
module xss_os_model
(
    input  wire logic                 sys_clk,
    input  wire xss_pkg::xss_wb_rsp_t wb_rsp,
    output xss_pkg::xss_wb_req_t      wb_req
);
    // ========================================================================
    // one bus cycle
    // ========================================================================
    // idle bus until the first request
    initial wb_req = '0;

    // the request is held until ack is sampled high at a rising edge
    task automatic cyc_go(input logic we, input logic [7:0] adr,
                          input logic [31:0] wd, output logic [31:0] rd);
        wb_req <= {2'b11, we, adr, 4'hf, wd};
        @(posedge sys_clk);
        while (wb_rsp.ack !== 1'b1)
            @(posedge sys_clk);
        rd = wb_rsp.dat;
        // released lines flip so a stale value can never pass as fresh
        wb_req <= {2'b00, ~we, ~adr, 4'h0, ~wd};
        @(posedge sys_clk);
    endtask
endmodule

/* tb/tb_top.sv */
// tb_top: self-checking bench for the extended state save block
// assumes the register map and command codes of xss_pkg
`timescale 1ns/1ps
module tb_top;
    logic                 sys_clk = 1'b0;
    logic                 resetn  = 1'b0;
    xss_pkg::xss_wb_req_t wb_req;
    xss_pkg::xss_wb_rsp_t wb_rsp;
    logic                 fault_nm;
    logic                 fault_gp;
    int                   num_errors = 0;
    int                   n_checks   = 0;
    int                   nm_n       = 0;
    int                   gp_n       = 0;

    // ========================================================================
    // clock, instances, fault pulse counters
    // ========================================================================
    // 200 MHz
    always #2.5 sys_clk = ~sys_clk;

    xss_top u_xss_top (.SYS_CLK(sys_clk), .RESETN(resetn), .WB_REQ(wb_req),
        .WB_RSP(wb_rsp), .FAULT_NM(fault_nm), .FAULT_GP(fault_gp));
    xss_os_model u_xss_os_model (.sys_clk(sys_clk), .wb_rsp(wb_rsp),
        .wb_req(wb_req));

    // pulses last one cycle, so each edge sees each at most once
    always @(posedge sys_clk)
    begin
        if (fault_nm === 1'b1) nm_n <= nm_n + 1;
        if (fault_gp === 1'b1) gp_n <= gp_n + 1;
    end

    // ========================================================================
    // shared tasks
    // ========================================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        u_xss_os_model.cyc_go(1'b1, a, d, x);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        u_xss_os_model.cyc_go(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask

    // issue a command and count the fault pulses that follow it
    task automatic op(input logic [3:0] c, input logic [1:0] r,
                      input logic [31:0] enm, input logic [31:0] egp);
        int n0;
        int g0;
        n0 = nm_n;
        g0 = gp_n;
        wr(xss_pkg::ADR_CMD, {26'h0, r, c});
        repeat (2) @(posedge sys_clk);
        chk(32'(nm_n - n0), enm);
        chk(32'(gp_n - g0), egp);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ========================================================================
    // scenarios
    // ========================================================================
    task automatic t_trap();
        rc(xss_pkg::ADR_IDENT, 32'h0400_0000);
        rc(8'h80, 32'h0);
        wr(xss_pkg::ADR_ECR, 32'h0004_0000);
        rc(xss_pkg::ADR_IDENT, 32'h0c00_0000);
        wr(xss_pkg::ADR_PCR, 32'h8);
        op(xss_pkg::OP_FPVEC, 2'h0, 1, 0);
        op(xss_pkg::OP_CHKSUM, 2'h3, 0, 0);
        op(xss_pkg::OP_BITCNT, 2'h3, 0, 0);
        wr(xss_pkg::ADR_OP_LO, 32'h3);
        op(xss_pkg::OP_SAVE, 2'h0, 1, 0);
        op(xss_pkg::OP_CLEAR_TASK_SWITCHED_OP, 2'h0, 0, 0);
        rc(xss_pkg::ADR_PCR, 32'h0);
        op(xss_pkg::OP_FPVEC, 2'h0, 0, 0);
        op(xss_pkg::OP_HWTSW, 2'h0, 0, 0);
        rc(xss_pkg::ADR_PCR, 32'h8);
        wr(xss_pkg::ADR_PCR, 32'h0);
        $display("test trap done");
    endtask

    // component 1 still disabled in the mask: restore must skip it
    task automatic t_disabled();
        wr(xss_pkg::ADR_AREA, 32'h40);
        wr(xss_pkg::ADR_IMG0, 32'h66);
        wr(xss_pkg::ADR_IMG1, 32'h77);
        wr(xss_pkg::ADR_HDR_BV, 32'h3);
        wr(xss_pkg::ADR_ST1, 32'h55);
        op(xss_pkg::OP_RESTORE, 2'h0, 0, 0);
        rc(xss_pkg::ADR_ST0, 32'h66);
        rc(xss_pkg::ADR_ST1, 32'h55);
        $display("test disabled done");
    endtask

    task automatic t_mask();
        op(xss_pkg::OP_RDMASK, 2'h3, 0, 0);
        rc(xss_pkg::ADR_RESULT, 32'h1);
        wr(xss_pkg::ADR_OP_LO, 32'h0);
        op(xss_pkg::OP_WRMASK, 2'h0, 0, 1);
        wr(xss_pkg::ADR_OP_LO, 32'h3);
        op(xss_pkg::OP_WRMASK, 2'h3, 0, 1);
        op(xss_pkg::OP_WRMASK, 2'h0, 0, 0);
        rc(xss_pkg::ADR_FM_LO, 32'h3);
        $display("test mask done");
    endtask

    task automatic t_image();
        wr(xss_pkg::ADR_ST0, 32'ha1);
        wr(xss_pkg::ADR_HDR_BV, 32'h0);
        wr(xss_pkg::ADR_OP_LO, 32'h1);
        op(xss_pkg::OP_SAVE, 2'h0, 0, 0);
        rc(xss_pkg::ADR_IMG0, 32'ha1);
        rc(xss_pkg::ADR_IMG1, 32'h77);
        rc(xss_pkg::ADR_HDR_BV, 32'h1);
        wr(xss_pkg::ADR_IMG1, 32'hc3);
        wr(xss_pkg::ADR_ST0, 32'h11);
        wr(xss_pkg::ADR_OP_LO, 32'h3);
        op(xss_pkg::OP_RESTORE, 2'h0, 0, 0);
        rc(xss_pkg::ADR_ST0, 32'ha1);
        rc(xss_pkg::ADR_ST1, 32'h0);
        wr(xss_pkg::ADR_ST1, 32'h55);
        wr(xss_pkg::ADR_OP_LO, 32'h1);
        op(xss_pkg::OP_RESTORE, 2'h0, 0, 0);
        rc(xss_pkg::ADR_ST1, 32'h55);
        wr(xss_pkg::ADR_AREA, 32'h41);
        op(xss_pkg::OP_SAVE, 2'h0, 0, 1);
        op(xss_pkg::OP_RESTORE, 2'h0, 0, 1);
        wr(xss_pkg::ADR_AREA, 32'h40);
        wr(xss_pkg::ADR_HDR_RS, 32'h1);
        op(xss_pkg::OP_RESTORE, 2'h0, 0, 1);
        rc(xss_pkg::ADR_STATUS, 32'h7);
        wr(xss_pkg::ADR_STATUS, 32'h7);
        rc(xss_pkg::ADR_STATUS, 32'h0);
        $display("test image done");
    endtask

    // ========================================================================
    // main sequence and watchdog
    // ========================================================================
    initial
    begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_trap();
        t_disabled();
        t_mask();
        t_image();
        report_and_stop();
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end
endmodule
